/* File: src/rsk_pkg.sv */
// Package of constants and helpers for the RGMII skew and in-band status block
package rsk_pkg;

    // Management register numbers of the indirect portal
    localparam logic [4:0]  PORTAL_CTL_ADDR   = 5'h0D;
    localparam logic [4:0]  PORTAL_DATA_ADDR  = 5'h0E;

    // Portal control word layout
    localparam int          PORTAL_FN_MSB     = 15;
    localparam int          PORTAL_FN_LSB     = 14;
    localparam int          PORTAL_DEV_MSB    = 4;
    localparam int          PORTAL_DEV_LSB    = 0;
    localparam logic [1:0]  PORTAL_FN_ADDRESS = 2'h0;
    localparam logic [1:0]  PORTAL_FN_DATA    = 2'h1;
    localparam logic [1:0]  PORTAL_FN_INC_RW  = 2'h2;
    localparam logic [1:0]  PORTAL_FN_INC_WR  = 2'h3;
    localparam logic [15:0] PORTAL_CTL_RST    = 16'h0000;
    localparam logic [15:0] PORTAL_DATA_RST   = 16'h0000;

    // Device space that holds the skew registers
    localparam logic [4:0]  SKEW_DEVICE       = 5'h02;

    // Skew register numbers inside that device space
    localparam logic [15:0] CONTROL_PIN_SKEW_OFS   = 16'h0004;
    localparam logic [15:0] RECEIVE_DATA_SKEW_OFS  = 16'h0005;
    localparam logic [15:0] TRANSMIT_DATA_SKEW_OFS = 16'h0006;
    localparam logic [15:0] CLOCK_PIN_SKEW_OFS     = 16'h0008;

    // Values after reset: every code at its no-adjustment value
    localparam logic [15:0] CONTROL_PIN_SKEW_RST   = 16'h0077;
    localparam logic [15:0] RECEIVE_DATA_SKEW_RST  = 16'h7777;
    localparam logic [15:0] TRANSMIT_DATA_SKEW_RST = 16'h7777;
    localparam logic [15:0] CLOCK_PIN_SKEW_RST     = 16'h01EF;

    // Field positions
    localparam int          RX_CTL_SKEW_LSB   = 4;
    localparam int          TX_CTL_SKEW_LSB   = 0;
    localparam int          TX_CLK_SKEW_LSB   = 5;
    localparam int          RX_CLK_SKEW_LSB   = 0;
    localparam int          NARROW_CODE_W     = 4;
    localparam int          CLOCK_CODE_W      = 5;
    localparam int          LANES             = 4;

    // Delay model: step size, centre codes, default clock lag
    localparam int          SKEW_STEP_PS      = 60;
    localparam logic [4:0]  NARROW_MID_CODE   = 5'h07;
    localparam logic [4:0]  CLOCK_MID_CODE    = 5'h0F;
    localparam int          RX_CLK_LAG_PS     = 1200;
    localparam int          TX_CLK_WINDOW_PS  = 500;

    // In-band status layout on the receive data pins
    localparam int          STAT_LINK_BIT     = 0;
    localparam int          STAT_SPEED_LSB    = 1;
    localparam int          STAT_DUPLEX_BIT   = 3;
    localparam logic [1:0]  SPEED_10          = 2'h0;
    localparam logic [1:0]  SPEED_100         = 2'h1;
    localparam logic [1:0]  SPEED_1000        = 2'h2;
    localparam logic [1:0]  SPEED_RESERVED    = 2'h3;
    localparam logic [3:0]  STATUS_RST        = 4'h0;

    // Signed delay offset in ps of a code against its centre code
    function automatic logic signed [11:0] rsk_skew_ps(input logic [4:0] code,
                                                       input logic [4:0] mid);
        logic signed [6:0]  diff;
        logic signed [13:0] prod;
        diff = $signed({2'h0, code}) - $signed({2'h0, mid});
        prod = diff * $signed(7'(SKEW_STEP_PS));
        return prod[11:0];
    endfunction : rsk_skew_ps

endpackage : rsk_pkg

/* File: src/rsk_status_if.sv */
// Interface carrying the in-band status word across to the receive clock domain
`timescale 1ns/1ns
interface rsk_status_if;
    logic [3:0] word;   // Status word, stable while a transfer is open
    logic       req;    // Toggle: new word offered
    logic       ack;    // Toggle: word taken on the link side

    // Register side offers the word
    modport src (output word, output req, input ack);
    // Link side takes the word
    modport dst (input word, input req, output ack);
endinterface : rsk_status_if

/* File: src/rsk_rx_inband.sv */
// Receive-side pin logic: inserts in-band status during the inter-frame gap
`timescale 1ns/1ns
module rsk_rx_inband (
    input  wire logic       rx_link_clk,
    input  wire logic       reset,
    rsk_status_if.dst       stat,
    input  wire logic       rx_frame_ctl,
    input  wire logic [3:0] rx_frame_data,
    output logic            rx_ctl_pin,
    output logic [3:0]      rxd_pin
);

    logic       req_s1_reg;   // First synchroniser stage
    logic       req_s2_reg;   // Second synchroniser stage
    logic       ack_reg;      // Returned toggle
    logic [3:0] status_reg;   // Status word in this domain

    // Bring the request toggle into the link clock domain
    always_ff @(posedge rx_link_clk or posedge reset)
    begin
        if (reset)
        begin
            req_s1_reg <= 1'h0;
            req_s2_reg <= 1'h0;
        end
        else
        begin
            req_s1_reg <= stat.req;
            req_s2_reg <= req_s1_reg;
        end
    end

    // Capture the word once the toggle shows a new offer
    always_ff @(posedge rx_link_clk or posedge reset)
    begin
        if (reset)
        begin
            status_reg <= rsk_pkg::STATUS_RST;
            ack_reg    <= 1'h0;
        end
        else if (req_s2_reg != ack_reg)
        begin
            status_reg <= stat.word;
            ack_reg    <= req_s2_reg;
        end
    end

    assign stat.ack = ack_reg;

    // Frame data while the control pin is high, status in the gap
    always_ff @(posedge rx_link_clk or posedge reset)
    begin
        if (reset)
        begin
            rx_ctl_pin <= 1'h0;
            rxd_pin    <= rsk_pkg::STATUS_RST;
        end
        else
        begin
            rx_ctl_pin <= rx_frame_ctl;
            if (rx_frame_ctl)
                rxd_pin <= rx_frame_data;
            else
                rxd_pin <= status_reg;
        end
    end

endmodule : rsk_rx_inband

/* File: src/rsk_skew_bank.sv */
// Skew register bank with indirect portal access and in-band status source
`timescale 1ns/1ns

// Functional notes
// - Four-bit codes per data pin, five-bit clocks
// - One code step moves delay about 60 ps
// - Four-bit centre 0111, range -0.42 to +0.48
// - Five-bit centre 01111, range -0.90 to +0.96
// - Control register: receive bits 7:4, transmit 3:0
// - Receive data codes in four nibbles
// - Transmit data codes in four nibbles
// - Clock register: transmit 9:5, receive 4:0
// - All fields writable, reset to centre codes
// - Default receive clock lags data 1.2 ns
// - Skew matters only inside each timing group
// - Status driven on data pins between frames
// - Data bit 3 duplex, bit 0 link
// - Bits 2:1 encode speed, 11 reserved
module rsk_skew_bank (
    input  wire logic               clk,
    input  wire logic               reset,
    // Management register port
    input  wire logic [4:0]         mgmt_addr,
    input  wire logic               mgmt_wr,
    input  wire logic               mgmt_rd,
    input  wire logic [15:0]        mgmt_wdata,
    output logic [15:0]             mgmt_rdata,
    output logic                    mgmt_rvalid,
    // Line status from the PHY core, same clock
    input  wire logic               link_up,
    input  wire logic               full_duplex,
    input  wire logic [1:0]         link_speed,
    // Receive link side
    input  wire logic               rx_link_clk,
    input  wire logic               rx_frame_ctl,
    input  wire logic [3:0]         rx_frame_data,
    output logic                    rx_ctl_pin,
    output logic [3:0]              rxd_pin,
    // Pad delay selections
    output logic [3:0]              tx_ctl_skew,
    output logic [3:0]              rx_ctl_skew,
    output logic [15:0]             rxd_skew,
    output logic [15:0]             txd_skew,
    output logic [4:0]              tx_clk_skew,
    output logic [4:0]              rx_clk_skew,
    // Delay estimates within each timing group
    output logic signed [12:0]      rx_clk_lag_ps,
    output logic signed [12:0]      tx_clk_offset_ps
);

    // Portal and skew storage
    logic [15:0] portal_ctl_reg;            // Function and device address
    logic [15:0] portal_addr_reg;           // Selected register number
    logic [15:0] control_pin_skew_reg;      // Control pin codes
    logic [15:0] receive_data_skew_reg;     // Receive data codes
    logic [15:0] transmit_data_skew_reg;    // Transmit data codes
    logic [15:0] clock_pin_skew_reg;        // Clock pin codes

    // Decoded access terms
    logic [1:0]  portal_fn;                 // Portal function field
    logic [4:0]  portal_dev;                // Portal device field
    logic        data_access;               // Data register used for a skew access
    logic        data_wr;                   // Write into a skew register
    logic        data_rd;                   // Read of a skew register
    logic        step_addr;                 // Post-increment after the access
    logic [15:0] skew_rdata;                // Read value of the addressed register

    // Status crossing
    rsk_status_if stat_if ();
    logic [3:0]  status_now;                // Current status word
    logic [3:0]  status_sent_reg;           // Word last offered
    logic        req_reg;                   // Request toggle
    logic        ack_s1_reg;                // First synchroniser stage
    logic        ack_s2_reg;                // Second synchroniser stage

    // Matches a register number against the selected one
    function automatic logic rsk_hit(input logic [15:0] addr, input logic [15:0] ofs);
        return addr == ofs;
    endfunction : rsk_hit

    // Portal field decode
    assign portal_fn   = portal_ctl_reg[rsk_pkg::PORTAL_FN_MSB:rsk_pkg::PORTAL_FN_LSB];
    assign portal_dev  = portal_ctl_reg[rsk_pkg::PORTAL_DEV_MSB:rsk_pkg::PORTAL_DEV_LSB];

    // A data access reaches the skew bank only in a data function for its device
    assign data_access = (mgmt_addr == rsk_pkg::PORTAL_DATA_ADDR)
                       && (portal_fn != rsk_pkg::PORTAL_FN_ADDRESS)
                       && (portal_dev == rsk_pkg::SKEW_DEVICE);
    assign data_wr     = data_access && mgmt_wr;
    assign data_rd     = data_access && mgmt_rd && !mgmt_wr;

    // Post-increment functions step the register number
    assign step_addr   = (data_wr && (portal_fn == rsk_pkg::PORTAL_FN_INC_WR))
                       || ((data_wr || data_rd)
                           && (portal_fn == rsk_pkg::PORTAL_FN_INC_RW));

    // Portal control register
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            portal_ctl_reg <= rsk_pkg::PORTAL_CTL_RST;
        else if (mgmt_wr && (mgmt_addr == rsk_pkg::PORTAL_CTL_ADDR))
            portal_ctl_reg <= mgmt_wdata;
    end

    // Portal address register: set in address function, stepped on increment
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            portal_addr_reg <= rsk_pkg::PORTAL_DATA_RST;
        else if (mgmt_wr && (mgmt_addr == rsk_pkg::PORTAL_DATA_ADDR)
                 && (portal_fn == rsk_pkg::PORTAL_FN_ADDRESS))
            portal_addr_reg <= mgmt_wdata;
        else if (step_addr)
            portal_addr_reg <= portal_addr_reg + 16'h0001;
    end

    // Control pin skew register
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            control_pin_skew_reg <= rsk_pkg::CONTROL_PIN_SKEW_RST;
        else if (data_wr && rsk_hit(portal_addr_reg, rsk_pkg::CONTROL_PIN_SKEW_OFS))
            control_pin_skew_reg <= mgmt_wdata;
    end

    // Receive data skew register
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            receive_data_skew_reg <= rsk_pkg::RECEIVE_DATA_SKEW_RST;
        else if (data_wr && rsk_hit(portal_addr_reg, rsk_pkg::RECEIVE_DATA_SKEW_OFS))
            receive_data_skew_reg <= mgmt_wdata;
    end

    // Transmit data skew register
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            transmit_data_skew_reg <= rsk_pkg::TRANSMIT_DATA_SKEW_RST;
        else if (data_wr && rsk_hit(portal_addr_reg, rsk_pkg::TRANSMIT_DATA_SKEW_OFS))
            transmit_data_skew_reg <= mgmt_wdata;
    end

    // Clock pin skew register
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            clock_pin_skew_reg <= rsk_pkg::CLOCK_PIN_SKEW_RST;
        else if (data_wr && rsk_hit(portal_addr_reg, rsk_pkg::CLOCK_PIN_SKEW_OFS))
            clock_pin_skew_reg <= mgmt_wdata;
    end

    // Read mux over the skew bank; unknown numbers read zero
    always_comb
    begin
        skew_rdata = 16'h0000;
        if (rsk_hit(portal_addr_reg, rsk_pkg::CONTROL_PIN_SKEW_OFS))
            skew_rdata = control_pin_skew_reg;
        else if (rsk_hit(portal_addr_reg, rsk_pkg::RECEIVE_DATA_SKEW_OFS))
            skew_rdata = receive_data_skew_reg;
        else if (rsk_hit(portal_addr_reg, rsk_pkg::TRANSMIT_DATA_SKEW_OFS))
            skew_rdata = transmit_data_skew_reg;
        else if (rsk_hit(portal_addr_reg, rsk_pkg::CLOCK_PIN_SKEW_OFS))
            skew_rdata = clock_pin_skew_reg;
    end

    // Registered read answer, one cycle after the strobe
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            mgmt_rdata  <= 16'h0000;
            mgmt_rvalid <= 1'h0;
        end
        else
        begin
            mgmt_rvalid <= mgmt_rd && !mgmt_wr;
            if (mgmt_rd && !mgmt_wr)
            begin
                case (mgmt_addr)
                    rsk_pkg::PORTAL_CTL_ADDR:
                        mgmt_rdata <= portal_ctl_reg;
                    rsk_pkg::PORTAL_DATA_ADDR:
                    begin
                        // Address function returns the number, data returns contents
                        if (portal_fn == rsk_pkg::PORTAL_FN_ADDRESS)
                            mgmt_rdata <= portal_addr_reg;
                        else if (data_access)
                            mgmt_rdata <= skew_rdata;
                        else
                            mgmt_rdata <= 16'h0000;
                    end
                    default:
                        mgmt_rdata <= 16'h0000;
                endcase
            end
        end
    end

    // Pad delay selections follow the registers directly
    always_comb
    begin
        rx_ctl_skew = control_pin_skew_reg[rsk_pkg::RX_CTL_SKEW_LSB +: rsk_pkg::NARROW_CODE_W];
        tx_ctl_skew = control_pin_skew_reg[rsk_pkg::TX_CTL_SKEW_LSB +: rsk_pkg::NARROW_CODE_W];
        tx_clk_skew = clock_pin_skew_reg[rsk_pkg::TX_CLK_SKEW_LSB +: rsk_pkg::CLOCK_CODE_W];
        rx_clk_skew = clock_pin_skew_reg[rsk_pkg::RX_CLK_SKEW_LSB +: rsk_pkg::CLOCK_CODE_W];
    end

    // One data lane code per nibble
    genvar lane;
    generate
        for (lane = 0; lane < rsk_pkg::LANES; lane++)
        begin : g_lane
            localparam int LSB = lane * rsk_pkg::NARROW_CODE_W;
            assign rxd_skew[LSB +: 4] = receive_data_skew_reg[LSB +: 4];
            assign txd_skew[LSB +: 4] = transmit_data_skew_reg[LSB +: 4];
        end
    endgenerate

    // Delay estimates inside each group, 60 ps per step about the centre
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            rx_clk_lag_ps    <= 13'(rsk_pkg::RX_CLK_LAG_PS);
            tx_clk_offset_ps <= 13'sh0000;
        end
        else
        begin
            // Receive clock lags control by the built-in amount plus code offsets
            rx_clk_lag_ps <= 13'(rsk_pkg::RX_CLK_LAG_PS)
                + 13'(rsk_pkg::rsk_skew_ps(rx_clk_skew, rsk_pkg::CLOCK_MID_CODE))
                - 13'(rsk_pkg::rsk_skew_ps({1'h0, rx_ctl_skew},
                                           rsk_pkg::NARROW_MID_CODE));
            // Transmit clock is taken as sent; the MAC supplies its skew
            tx_clk_offset_ps <=
                13'(rsk_pkg::rsk_skew_ps(tx_clk_skew, rsk_pkg::CLOCK_MID_CODE))
                - 13'(rsk_pkg::rsk_skew_ps({1'h0, tx_ctl_skew},
                                           rsk_pkg::NARROW_MID_CODE));
        end
    end

    // Assemble the in-band status word; a reserved speed is sent as the slowest
    always_comb
    begin
        status_now = rsk_pkg::STATUS_RST;
        status_now[rsk_pkg::STAT_DUPLEX_BIT] = full_duplex;
        status_now[rsk_pkg::STAT_LINK_BIT]   = link_up;
        case (link_speed)
            rsk_pkg::SPEED_10:
                status_now[rsk_pkg::STAT_SPEED_LSB +: 2] = rsk_pkg::SPEED_10;
            rsk_pkg::SPEED_100:
                status_now[rsk_pkg::STAT_SPEED_LSB +: 2] = rsk_pkg::SPEED_100;
            rsk_pkg::SPEED_1000:
                status_now[rsk_pkg::STAT_SPEED_LSB +: 2] = rsk_pkg::SPEED_1000;
            default:
                status_now[rsk_pkg::STAT_SPEED_LSB +: 2] = rsk_pkg::SPEED_10;
        endcase
    end

    // Bring the returned toggle back into this domain
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ack_s1_reg <= 1'h0;
            ack_s2_reg <= 1'h0;
        end
        else
        begin
            ack_s1_reg <= stat_if.ack;
            ack_s2_reg <= ack_s1_reg;
        end
    end

    // Offer a new word only when the last one was taken, so the word stays stable
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            status_sent_reg <= rsk_pkg::STATUS_RST;
            req_reg         <= 1'h0;
        end
        else if ((ack_s2_reg == req_reg) && (status_now != status_sent_reg))
        begin
            status_sent_reg <= status_now;
            req_reg         <= ~req_reg;
        end
    end

    assign stat_if.word = status_sent_reg;
    assign stat_if.req  = req_reg;

    // Receive pin logic on the link clock
    rsk_rx_inband u_rx_inband (
        .rx_link_clk   (rx_link_clk),
        .reset         (reset),
        .stat          (stat_if),
        .rx_frame_ctl  (rx_frame_ctl),
        .rx_frame_data (rx_frame_data),
        .rx_ctl_pin    (rx_ctl_pin),
        .rxd_pin       (rxd_pin)
    );

endmodule : rsk_skew_bank

/* File: testbench/rsk_skew_bank_checker.sv */
// Port checker for the skew register bank
`timescale 1ns/1ns
module rsk_skew_bank_checker (
    input wire logic               clk,
    input wire logic               reset,
    input wire logic               mgmt_wr,
    input wire logic               mgmt_rd,
    input wire logic [15:0]        mgmt_rdata,
    input wire logic               mgmt_rvalid,
    input wire logic               rx_link_clk,
    input wire logic               rx_frame_ctl,
    input wire logic [3:0]         rx_frame_data,
    input wire logic               rx_ctl_pin,
    input wire logic [3:0]         rxd_pin,
    input wire logic [3:0]         tx_ctl_skew,
    input wire logic [3:0]         rx_ctl_skew,
    input wire logic [15:0]        rxd_skew,
    input wire logic [15:0]        txd_skew,
    input wire logic [4:0]         tx_clk_skew,
    input wire logic [4:0]         rx_clk_skew,
    input wire logic signed [12:0] rx_clk_lag_ps,
    input wire logic signed [12:0] tx_clk_offset_ps
);
    // Answer comes exactly one cycle after an accepted read
    property p_read_answer;
        @(posedge clk) disable iff (reset) mgmt_rd && !mgmt_wr |=> mgmt_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    // No answer without a read
    property p_no_stray;
        @(posedge clk) disable iff (reset) mgmt_rvalid |-> $past(mgmt_rd && !mgmt_wr);
    endproperty
    a_no_stray: assert property (p_no_stray) else $error("answer without read");
    // Read data holds between answers
    property p_rdata_holds;
        @(posedge clk) disable iff (reset) !mgmt_rvalid |-> $stable(mgmt_rdata);
    endproperty
    a_rdata_holds: assert property (p_rdata_holds) else $error("read data moved");
    // Codes change only through a write
    property p_codes_hold;
        @(posedge clk) disable iff (reset) !mgmt_wr |=> $stable({tx_ctl_skew, rx_ctl_skew,
            rxd_skew, txd_skew, tx_clk_skew, rx_clk_skew});
    endproperty
    a_codes_hold: assert property (p_codes_hold) else $error("code moved");
    // Receive clock lag follows the linear step model
    property p_rx_lag;
        @(posedge clk) disable iff (reset) 1'b1 |=> rx_clk_lag_ps == $signed(13'(1200
            + 60 * (int'($past(rx_clk_skew)) - 15) - 60 * (int'($past(rx_ctl_skew)) - 7)));
    endproperty
    a_rx_lag: assert property (p_rx_lag) else $error("receive lag wrong");
    // Transmit offset follows the same model inside its group
    property p_tx_offset;
        @(posedge clk) disable iff (reset) 1'b1 |=> tx_clk_offset_ps == $signed(13'(
            60 * (int'($past(tx_clk_skew)) - 15) - 60 * (int'($past(tx_ctl_skew)) - 7)));
    endproperty
    a_tx_offset: assert property (p_tx_offset) else $error("transmit offset wrong");
    // Frame nibbles pass to the pins one link cycle later
    property p_frame_pass;
        @(posedge rx_link_clk) disable iff (reset)
            rx_frame_ctl |=> rx_ctl_pin && rxd_pin == $past(rx_frame_data);
    endproperty
    a_frame_pass: assert property (p_frame_pass) else $error("frame nibble lost");
    // Gap shows control low and never the reserved speed
    property p_gap_status;
        @(posedge rx_link_clk) disable iff (reset)
            !rx_frame_ctl |=> !rx_ctl_pin && rxd_pin[2:1] != 2'h3;
    endproperty
    a_gap_status: assert property (p_gap_status) else $error("gap status wrong");
endmodule : rsk_skew_bank_checker

bind rsk_skew_bank rsk_skew_bank_checker u_chk (.*);

/* File: testbench/rsk_rx_source.sv */
// Receive datapath model feeding random frames toward the pins
`timescale 1ns/1ns
module rsk_rx_source (
    input  wire logic       rx_link_clk,
    input  wire logic       reset,
    input  wire logic       frames_on,
    output logic            rx_frame_ctl,
    output logic [3:0]      rx_frame_data
);
    integer seed = 4;  // Repeatable frame pattern
    integer left = 0;  // Nibbles left in the frame
    // Frames of random length; data toggles between frames, the MAC owns its skew
    always @(posedge rx_link_clk or posedge reset)
    begin
        if (reset)
        begin
            rx_frame_ctl <= 1'b0;
            rx_frame_data <= 4'h0;
            left <= 0;
        end
        else if (left > 0)
        begin
            left <= left - 1;
            rx_frame_ctl <= 1'b1;
            rx_frame_data <= 4'($random(seed));
        end
        else
        begin
            rx_frame_ctl <= 1'b0;
            rx_frame_data <= ~rx_frame_data;
            if (frames_on && ($random(seed) & 3) == 0)
                left <= 3 + ($random(seed) & 15);
        end
    end
endmodule : rsk_rx_source

/* File: testbench/test_rsk_skew_bank.sv */
// Self-checking bench for the skew register bank
`timescale 1ns/1ns
module test_rsk_skew_bank;
    logic               clk, reset, rx_link_clk, frames_on;        // Clocks and controls
    logic [4:0]         mgmt_addr;                                 // Register number
    logic               mgmt_wr, mgmt_rd, mgmt_rvalid;             // Strobes and answer
    logic [15:0]        mgmt_wdata, mgmt_rdata, v;                 // Data words
    logic               link_up, full_duplex, rx_frame_ctl, rx_ctl_pin; // Status bits
    logic [1:0]         link_speed;                                // Speed code
    logic [3:0]         rx_frame_data, rxd_pin, tx_ctl_skew, rx_ctl_skew; // Nibbles
    logic [15:0]        rxd_skew, txd_skew;                        // Data lane codes
    logic [4:0]         tx_clk_skew, rx_clk_skew;                  // Clock codes
    logic signed [12:0] rx_clk_lag_ps, tx_clk_offset_ps;           // Delay estimates
    logic [15:0]        sh [4];                                    // Expected registers
    logic [15:0]        dflt [4] = '{16'h0077, 16'h7777, 16'h7777, 16'h01EF}; // After reset
    logic [15:0]        ofs [4] = '{16'h0004, 16'h0005, 16'h0006, 16'h0008};  // Numbers
    integer             seed, bad_count, checks_done, r;           // Bench state

    rsk_skew_bank DUT (.*);
    rsk_rx_source u_src (.*);

    // System clock, 50 ns
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Link clock, 15 ns, offset phase
    initial
    begin
        rx_link_clk = 1'b0;
        #3;
        forever
        begin
            #7 rx_link_clk = 1'b1;
            #8 rx_link_clk = 1'b0;
        end
    end
    // Comparison and verdict
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    // Management cycles
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clk);
        mgmt_addr = a;
        mgmt_wdata = d;
        mgmt_wr = 1'b1;
        @(negedge clk);
        mgmt_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        int n;
        @(negedge clk);
        mgmt_addr = a;
        mgmt_rd = 1'b1;
        @(negedge clk);
        mgmt_rd = 1'b0;
        for (n = 0; n < 8 && mgmt_rvalid !== 1'b1; n++) @(negedge clk);
        if (n == 8)
        begin
            bad_count++;
            test_done();
        end
        d = mgmt_rdata;
    endtask : rd
    // Select a register of device space 2 through the portal
    task automatic portal(input logic [15:0] num);
        wr(5'h0D, 16'h0002);
        wr(5'h0E, num);
        wr(5'h0D, 16'h4002);
    endtask : portal
    // Delay estimate from codes
    function automatic logic [15:0] lag(input int ck, input int ct, input int base);
        return 16'(base + 60 * (ck - 15) - 60 * (ct - 7));
    endfunction : lag
    // In-band status word, reserved speed sent as 00
    function automatic logic [3:0] stat(input logic l, input logic d, input logic [1:0] s);
        return {d, (s == 2'h3) ? 2'h0 : s, l};
    endfunction : stat
    // Read back every register and compare all pad outputs
    task automatic check_all();
        int i;
        logic [15:0] q;
        for (i = 0; i < 4; i++)
        begin
            portal(ofs[i]);
            rd(5'h0E, q);
            chk(q, sh[i]);
        end
        chk({8'h00, rx_ctl_skew, tx_ctl_skew}, {8'h00, sh[0][7:0]});
        chk(rxd_skew, sh[1]);
        chk(txd_skew, sh[2]);
        chk({6'h00, tx_clk_skew, rx_clk_skew}, {6'h00, sh[3][9:0]});
        chk(16'(rx_clk_lag_ps), lag(sh[3][4:0], sh[0][7:4], 1200));
        chk(16'(tx_clk_offset_ps), lag(sh[3][9:5], sh[0][3:0], 0));
    endtask : check_all
    // Hold a random line status and read it off the pins in the gap
    task automatic status_check(input logic [1:0] s);
        @(negedge clk);
        frames_on = 1'b0;
        link_up = 1'($random(seed));
        full_duplex = 1'($random(seed));
        link_speed = s;
        repeat (40) @(negedge clk);
        @(negedge rx_link_clk);
        chk({12'h000, rxd_pin}, {12'h000, stat(link_up, full_duplex, s)});
        chk({15'h0000, rx_ctl_pin}, 16'h0000);
        frames_on = 1'b1;
    endtask : status_check
    // Main sequence
    initial
    begin
        seed = 4;
        bad_count = 0;
        checks_done = 0;
        reset = 1'b1;
        {mgmt_addr, mgmt_wr, mgmt_rd, mgmt_wdata} = '0;
        {link_up, full_duplex, link_speed, frames_on} = '0;
        sh = dflt;
        repeat (6) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        frames_on = 1'b1;
        check_all();
        // All zero, all ones, then random words into each register
        for (r = 0; r < 16; r++)
        begin
            v = (r < 4) ? 16'h0000 : (r < 8) ? 16'hFFFF : 16'($random(seed));
            sh[r % 4] = v;
            portal(ofs[r % 4]);
            wr(5'h0E, v);
            if (r % 4 == 3)
                check_all();
        end
        portal(16'h0007);
        rd(5'h0E, v);
        chk(v, 16'h0000);
        rd(5'h01, v);
        chk(v, 16'h0000);
        for (r = 0; r < 4; r++) status_check(2'(r));
        @(negedge clk);
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        sh = dflt;
        check_all();
        test_done();
    end
endmodule : test_rsk_skew_bank
